// >>> dscr_consts.vh
/*
 * Constants of the chained serial converter interface: word width,
 * power-up code and buffer sizing.
 * Assumes it is included by its bare name by the design file.
 */
`ifndef DSCR_CONSTS_VH
`define DSCR_CONSTS_VH

// ****************************************************************
// Word and reset values
// ****************************************************************
`define DSCR_WORD_W     16
`define DSCR_MIDSCALE   16'h8000
`define DSCR_CNT_W      5
`define DSCR_WORD_BITS  5'h10

// ****************************************************************
// Word buffer between frame logic and input register
// ****************************************************************
`define DSCR_FIFO_DEPTH 8
`define DSCR_FIFO_AW    3

`endif

// >>> dscr_chain.v
/*
 * Serial shift path of a 16-bit converter control port: chained
 * shifting, readback of the converter register and the two update
 * modes, plus the small word buffer that feeds the input register.
 * Assumes all pins are asynchronous to CLK (shift clock well below
 * CLK/4) and that the host keeps the frame rules of the chain.
 */
`timescale 1ns/10ps
`include "dscr_consts.vh"

// ****************************************************************
// Word buffer
// ****************************************************************
module dscr_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             srst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wr_r;
   reg [AW-1:0]    rd_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   // Full level at counter width, so the compare needs no truncation
   localparam [AW:0] FULL_CNT = DEPTH;

   assign in_ready  = (cnt_r != FULL_CNT);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         wr_r  <= {AW{1'b0}};
         rd_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // dscr_fifo

// ****************************************************************
// Chained shift path
// ****************************************************************
// What this block does
// - Frame select low: shift data input in on each shift clock fall.
// - Beyond sixteen pulses, bits leave the far end onto the data output.
// - First word sent lands in the farthest device after the last word.
// - Host raises frame select when done; shift edges then are ignored.
// - Shared load strobe low updates all converter registers together.
// - In a frame the converter register leads out, one bit per fall.
// - From fall seventeen the output repeats the input sixteen falls late.
// - Whole chain reads back via the last device with summed latency.
// - Power-up loads midscale into shift register and converter register.
// - At the end of a frame of sixteen or more falls the shift register moves into the input register.
// - Load strobe low during a frame of sixteen or more falls updates on the frame select rise.
// - Load strobe high during shifting updates on its later falling edge.
module dscr_chain (
   input  wire        CLK,
   input  wire        SRST,
   input  wire        SHIFT_CLOCK,
   input  wire        FRAME_SELECT_N,
   input  wire        SERIAL_IN_LINE,
   input  wire        LOAD_STROBE_N,
   output reg         SERIAL_OUT_LINE,
   output reg  [15:0] INPUT_CODE,
   output reg  [15:0] DAC_CODE,
   output reg         WORD_DROPPED
);
   // Two-flop synchronisers; stage one feeds stage two only
   reg [3:0]  meta_r;
   reg [3:0]  sync_r;
   reg        sclk_d_r;
   reg        fsel_d_r;
   reg        load_strobe_n_d_r;

   reg [`DSCR_WORD_W-1:0] shreg_r;
   reg [`DSCR_CNT_W-1:0]  cnt_r;
   reg        load_strobe_n_seen_r;
   reg        upd_pend_r;
   reg        push_r;
   reg [`DSCR_WORD_W-1:0] push_data_r;

   wire       sclk_s = sync_r[0];
   wire       fsel_s = sync_r[1];
   wire       serial_in_line_s = sync_r[2];
   wire       load_strobe_n_s = sync_r[3];
   wire       sclk_fall = sclk_d_r & ~sclk_s;
   wire       fsel_fall = fsel_d_r & ~fsel_s;
   wire       fsel_rise = ~fsel_d_r & fsel_s;
   wire       load_strobe_n_fall = load_strobe_n_d_r & ~load_strobe_n_s;

   wire [`DSCR_WORD_W-1:0] buf_data;
   wire       buf_valid;
   wire       buf_in_ready;

   always @(posedge CLK) begin
      if (SRST) begin
         meta_r   <= 4'hb;
         sync_r   <= 4'hb;
         sclk_d_r <= 1'b1;
         fsel_d_r <= 1'b1;
         load_strobe_n_d_r <= 1'b1;
      end else begin
         meta_r   <= {LOAD_STROBE_N, SERIAL_IN_LINE, FRAME_SELECT_N,
                      SHIFT_CLOCK};
         sync_r   <= meta_r;
         sclk_d_r <= sclk_s;
         fsel_d_r <= fsel_s;
         load_strobe_n_d_r <= load_strobe_n_s;
      end
   end

   // ****************************************************************
   // Frame shifting and readback
   // ****************************************************************
   always @(posedge CLK) begin
      if (SRST) begin
         shreg_r         <= `DSCR_MIDSCALE;
         cnt_r           <= {`DSCR_CNT_W{1'b0}};
         SERIAL_OUT_LINE <= 1'b0;
         load_strobe_n_seen_r     <= 1'b0;
         push_r          <= 1'b0;
         push_data_r     <= `DSCR_MIDSCALE;
      end else begin
         push_r <= 1'b0;
         if (fsel_fall) begin
            // Preload so the converter register leads out, then input
            shreg_r     <= DAC_CODE;
            cnt_r       <= {`DSCR_CNT_W{1'b0}};
            load_strobe_n_seen_r <= ~load_strobe_n_s;
         end else if (~fsel_s) begin
            if (~load_strobe_n_s) begin
               load_strobe_n_seen_r <= 1'b1;
            end
            if (sclk_fall) begin
               // MSB out first; input emerges 16 falls later
               SERIAL_OUT_LINE <= shreg_r[`DSCR_WORD_W-1];
               shreg_r <= {shreg_r[`DSCR_WORD_W-2:0], serial_in_line_s};
               if (cnt_r != `DSCR_WORD_BITS) begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
         end else if (fsel_rise && cnt_r == `DSCR_WORD_BITS) begin
            // Short frames leave the input register alone
            push_r      <= 1'b1;
            push_data_r <= shreg_r;
         end
         // With frame select high only the push on its rise changes: the rest holds
      end
   end

   // ****************************************************************
   // Input and converter registers
   // ****************************************************************
   // Drain stalls during a frame so input register changes only
   // between frames; a full buffer drops the word and flags it.
   always @(posedge CLK) begin
      if (SRST) begin
         INPUT_CODE   <= `DSCR_MIDSCALE;
         DAC_CODE     <= `DSCR_MIDSCALE;
         upd_pend_r   <= 1'b0;
         WORD_DROPPED <= 1'b0;
      end else begin
         if (push_r & ~buf_in_ready) begin
            WORD_DROPPED <= 1'b1;
         end
         if (buf_valid & fsel_s) begin
            INPUT_CODE <= buf_data;
         end
         if ((push_r & load_strobe_n_seen_r) | (fsel_s & load_strobe_n_fall)) begin
            upd_pend_r <= 1'b1;
         end else if (upd_pend_r & ~buf_valid) begin
            // Wait until the buffer has drained into the input register
            DAC_CODE   <= INPUT_CODE;
            upd_pend_r <= 1'b0;
         end
      end
   end

   dscr_fifo #(
      .WIDTH (`DSCR_WORD_W),
      .DEPTH (`DSCR_FIFO_DEPTH),
      .AW    (`DSCR_FIFO_AW)
   ) u_buf (
      .clk       (CLK),
      .srst      (SRST),
      .in_data   (push_data_r),
      .in_valid  (push_r),
      .in_ready  (buf_in_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (fsel_s)
   );
endmodule // dscr_chain

// >>> dscr_chain_asserts.sv
/* Port checker for dscr_chain.
   Assumes host pins follow the frame rules. */
`timescale 1ns/10ps
module dscr_chain_asserts (
   input wire        CLK,
   input wire        SRST,
   input wire        SHIFT_CLOCK,
   input wire        FRAME_SELECT_N,
   input wire        LOAD_STROBE_N,
   input wire        SERIAL_OUT_LINE,
   input wire [15:0] INPUT_CODE,
   input wire [15:0] DAC_CODE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   chk_out_hold: assert property (
      FRAME_SELECT_N [*5] |-> $stable(SERIAL_OUT_LINE)) else $error("out moved");
   chk_out_on_fall: assert property (
      $changed(SERIAL_OUT_LINE) |-> !$past(SHIFT_CLOCK, 3)
      && $past(SHIFT_CLOCK, 6)) else $error("out without fall");
   chk_input_load: assert property (
      $changed(INPUT_CODE) |-> FRAME_SELECT_N
      && $past(FRAME_SELECT_N, 4)) else $error("input early");
   chk_dac_source: assert property (
      $changed(DAC_CODE) |-> DAC_CODE == $past(INPUT_CODE))
      else $error("dac source");
   chk_dac_idle: assert property (
      LOAD_STROBE_N [*8] |-> $stable(DAC_CODE)) else $error("dac moved");
   chk_frame_dac: assert property (
      !FRAME_SELECT_N [*8] |-> $stable(DAC_CODE)) else $error("dac in frame");
   chk_sync_upd: assert property (
      $rose(FRAME_SELECT_N) && !LOAD_STROBE_N |-> ##[5:10]
      DAC_CODE == INPUT_CODE) else $error("no sync update");
   chk_async_upd: assert property (
      $fell(LOAD_STROBE_N) && FRAME_SELECT_N |-> ##[3:8]
      DAC_CODE == INPUT_CODE) else $error("no strobe update");
endmodule // dscr_chain_asserts

// >>> dscr_host.sv
/* Host serial controller model.
   Assumes clk paces every pin change. */
`timescale 1ns/10ps
module dscr_host (
   input  wire        clk,
   input  wire        serial_out_line,
   output reg         sck_r,
   output reg         fs_n_r,
   output reg         sdi_r,
   output reg         ld_n_r,
   output reg  [31:0] rb_r
);
   // ***
   // Frame of n falls, MSB first
   // ***
   task frame(input [31:0] w, input integer n, input s);
      integer i;
      begin
         fs_n_r = 0;
         ld_n_r = !s;
         for (i = n - 1; i >= 0; i = i - 1) begin
            sdi_r = w[i];
            repeat (4) @(negedge clk);
            rb_r = {rb_r[30:0], serial_out_line};
            sck_r = 0;
            repeat (4) @(negedge clk);
            sck_r = 1;
         end
         repeat (4) @(negedge clk);
         rb_r = {rb_r[30:0], serial_out_line};
         fs_n_r = 1;
         sdi_r = !sdi_r;
         // Strobe stays low past the update so it is never a new fall
         repeat (12) @(negedge clk);
         ld_n_r = 1;
         repeat (8) @(negedge clk);
      end
   endtask
   task pulse_ld;
      begin
         ld_n_r = 0;
         repeat (4) @(negedge clk);
         ld_n_r = 1;
         repeat (12) @(negedge clk);
      end
   endtask
   // Odd count of falls, so a leaking shift would show on the output
   task idle_clk;
      integer i;
      for (i = 0; i < 6; i = i + 1) begin
         sck_r = !sck_r;
         repeat (4) @(negedge clk);
      end
   endtask
   initial begin
      sck_r = 1;
      fs_n_r = 1;
      sdi_r = 0;
      ld_n_r = 1;
      rb_r = 0;
   end
endmodule // dscr_host

// >>> tb.sv
/* Self-checking bench for dscr_chain.
   Assumes the host model drives all pins. */
`timescale 1ns/10ps
module tb;
   reg         CLK;
   reg         SRST;
   wire        sck, fs_n, sdi, ld_n, serial_out_line, drop;
   wire [15:0] in_c, dac_c;
   wire [31:0] rb;
   integer     miscompares, checked, k;
   reg  [16:0] rows [0:3];
   reg  [15:0] dac;
   dscr_chain DUT (.CLK(CLK), .SRST(SRST), .SHIFT_CLOCK(sck),
      .FRAME_SELECT_N(fs_n), .SERIAL_IN_LINE(sdi), .LOAD_STROBE_N(ld_n),
      .SERIAL_OUT_LINE(serial_out_line), .INPUT_CODE(in_c), .DAC_CODE(dac_c),
      .WORD_DROPPED(drop));
   dscr_host HOST (.clk(CLK), .serial_out_line(serial_out_line), .sck_r(sck), .fs_n_r(fs_n),
      .sdi_r(sdi), .ld_n_r(ld_n), .rb_r(rb));
   always #25 CLK = !CLK;
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task close_out;
      begin
         $display("checked %0d miscompares %0d", checked, miscompares);
         if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #1000000;
      miscompares = miscompares + 1;
      close_out;
   end
   initial begin
      CLK = 0;
      SRST = 1;
      checked = 0;
      miscompares = 0;
      dac = 16'h8000;
      rows[0] = {1'b1, 16'h1234};
      rows[1] = {1'b0, 16'hfffe};
      rows[2] = {1'b1, 16'h0001};
      rows[3] = {1'b0, 16'h8001};
      repeat (10) @(negedge CLK);
      SRST = 0;
      chk("input", 16'h8000, in_c);
      chk("dac", 16'h8000, dac_c);
      for (k = 0; k < 4; k = k + 1) begin
         HOST.frame(rows[k][15:0], 16, rows[k][16]);
         chk("readback", dac, rb[15:0]);
         chk("input", rows[k][15:0], in_c);
         if (rows[k][16])
            dac = rows[k][15:0];
         chk("dac", dac, dac_c);
         HOST.pulse_ld;
         dac = rows[k][15:0];
         chk("dac", dac, dac_c);
         $display("row %0d done", k);
      end
      // Two words: the first one leaves through the output late
      HOST.frame(32'ha5a55a5a, 32, 1'b0);
      chk("readback", {dac, 16'ha5a5}, rb);
      chk("input", 16'h5a5a, in_c);
      chk("dac", dac, dac_c);
      HOST.idle_clk;
      chk("out", 1, serial_out_line);
      HOST.frame(32'h0f, 8, 1'b0);
      chk("input", 16'h5a5a, in_c);
      chk("dropped", 0, drop);
      $display("chain tests done");
      SRST = 1;
      repeat (2) @(negedge CLK);
      SRST = 0;
      chk("input", 16'h8000, in_c);
      chk("dac", 16'h8000, dac_c);
      chk("dropped", 0, drop);
      close_out;
   end
endmodule // tb
bind dscr_chain dscr_chain_asserts CHK (.CLK(CLK), .SRST(SRST),
   .SHIFT_CLOCK(SHIFT_CLOCK), .FRAME_SELECT_N(FRAME_SELECT_N),
   .LOAD_STROBE_N(LOAD_STROBE_N), .SERIAL_OUT_LINE(SERIAL_OUT_LINE),
   .INPUT_CODE(INPUT_CODE), .DAC_CODE(DAC_CODE));
